// ---- rtl/lsp_pkg.sv ----
// Package: constants for the LCD-shared I/O port multiplexer
`default_nettype none

package lsp_pkg;

    // ==========================================================
    // Bus geometry
    // ==========================================================
    localparam int LSP_ADDR_W = 18;                 // Byte address width
    localparam int LSP_DATA_W = 32;                 // APB data width
    localparam int LSP_REG_W  = 8;                  // Register width

    // ==========================================================
    // Register indices (byte address = 4 x index)
    // ==========================================================
    localparam logic [15:0] LSP_IDX_P8_DATA  = 16'hffdb;  // Port 8 data
    localparam logic [15:0] LSP_IDX_P8_DIR   = 16'hffeb;  // Port 8 direction
    localparam logic [15:0] LSP_IDX_PA_DATA  = 16'hffdd;  // Port A data
    localparam logic [15:0] LSP_IDX_PA_DIR   = 16'hffed;  // Port A direction
    localparam logic [15:0] LSP_IDX_LCD_CTRL = 16'hffc0;  // LCD port control
    localparam logic [15:0] LSP_IDX_PWR_MODE = 16'hffc1;  // Operating mode

    localparam logic [17:0] LSP_ADDR_P8_DATA  = {LSP_IDX_P8_DATA, 2'b00};
    localparam logic [17:0] LSP_ADDR_P8_DIR   = {LSP_IDX_P8_DIR, 2'b00};
    localparam logic [17:0] LSP_ADDR_PA_DATA  = {LSP_IDX_PA_DATA, 2'b00};
    localparam logic [17:0] LSP_ADDR_PA_DIR   = {LSP_IDX_PA_DIR, 2'b00};
    localparam logic [17:0] LSP_ADDR_LCD_CTRL = {LSP_IDX_LCD_CTRL, 2'b00};
    localparam logic [17:0] LSP_ADDR_PWR_MODE = {LSP_IDX_PWR_MODE, 2'b00};

    // ==========================================================
    // Reset values and fixed bits
    // ==========================================================
    localparam logic [7:0] LSP_P8_RESET    = 8'h00;   // Port 8 data and direction
    localparam logic [7:0] LSP_PA_RESET    = 8'hf0;   // Port A data and direction
    localparam logic [7:0] LSP_PA_FIXED    = 8'hf0;   // Unused port A bits, read 1
    localparam logic [7:0] LSP_PA_MASK     = 8'h0f;   // Live port A bits
    localparam logic [7:0] LSP_DIR_READ    = 8'hff;   // Write-only direction reads
    localparam logic [7:0] LSP_LCD_RESET   = 8'h00;   // LCD port control
    localparam logic [7:0] LSP_LCD_MASK    = 8'h1f;   // Implemented control bits

    // ==========================================================
    // LCD port control field layout
    // ==========================================================
    localparam int LSP_SGS_LSB = 0;                 // Segment select field
    localparam int LSP_SGS_W   = 4;
    localparam int LSP_SGX_BIT = 4;                 // Interface select bit

    // ==========================================================
    // Pin layout
    // ==========================================================
    localparam int LSP_P8_PINS   = 7;               // Port 8 pins 6..0 handled here
    localparam int LSP_P8_IF_LSB = 4;               // First pin with interface use
    localparam int LSP_PA_PINS   = 4;               // Port A pins 3..0

    // ==========================================================
    // Operating modes
    // ==========================================================
    typedef enum logic [2:0] {
        LSP_MODE_ACTIVE    = 3'h0,
        LSP_MODE_SUBACTIVE = 3'h1,
        LSP_MODE_SLEEP     = 3'h2,
        LSP_MODE_SUBSLEEP  = 3'h3,
        LSP_MODE_WATCH     = 3'h4,
        LSP_MODE_STANDBY   = 3'h5
    } lsp_mode_t;

endpackage : lsp_pkg

`default_nettype wire

// ---- rtl/lsp_sync.sv ----
// Two-flop synchroniser for pad input levels
`default_nettype none

module lsp_sync #(
    parameter int W = 1                     // Number of bits
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    // ==========================================================
    // Stages
    // ==========================================================
    logic [W-1:0] meta_q;                   // First stage, read only by second
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;                   // Second stage, safe to use
    logic [W-1:0] sync_d;

    // Next values: shift one stage per clock
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : lsp_sync

`default_nettype wire

// ---- rtl/lsp_port_mux.sv ----
// Top: APB registers and pad multiplexer for the LCD-shared I/O ports
`default_nettype none

module lsp_port_mux
    import lsp_pkg::*;
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // LCD controller side
    input  wire logic [6:0]  lcd_column_drive,
    input  wire logic        lcd_shift_pulse,
    input  wire logic        lcd_serial_data,
    input  wire logic        lcd_polarity,
    input  wire logic [3:0]  lcd_backplane,
    // Port 8 pads, pins 6..0
    input  wire logic [6:0]  port8_pin_in,
    output logic      [6:0]  port8_pin_out,
    output logic      [6:0]  port8_pin_oe,
    // Port A pads, pins 3..0
    input  wire logic [3:0]  port_a_pin_in,
    output logic      [3:0]  port_a_pin_out,
    output logic      [3:0]  port_a_pin_oe
);

    // ==========================================================
    // Pad input synchronisers
    // ==========================================================
    logic [6:0] p8_pin_s;                   // Port 8 levels, in pclk domain
    logic [3:0] pa_pin_s;                   // Port A levels, in pclk domain

    // Pads are asynchronous to pclk, so two flops first
    lsp_sync #(
        .W        (LSP_P8_PINS)
    ) u_sync_p8 (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (port8_pin_in),
        .sync_out (p8_pin_s)
    );

    lsp_sync #(
        .W        (LSP_PA_PINS)
    ) u_sync_pa (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (port_a_pin_in),
        .sync_out (pa_pin_s)
    );

    // ==========================================================
    // APB decode
    // ==========================================================
    logic setup_ph;                         // First cycle of a transfer
    logic access_ph;                        // Completing cycle
    logic sel_p8_data;                      // Address hits
    logic sel_p8_dir;
    logic sel_pa_data;
    logic sel_pa_dir;
    logic sel_lcd;
    logic sel_mode;
    logic addr_hit;                         // Any register hit
    logic wr_en;                            // Write commits this edge

    always_comb begin
        setup_ph    = psel & ~penable;
        access_ph   = psel & penable;
        sel_p8_data = (paddr == LSP_ADDR_P8_DATA);
        sel_p8_dir  = (paddr == LSP_ADDR_P8_DIR);
        sel_pa_data = (paddr == LSP_ADDR_PA_DATA);
        sel_pa_dir  = (paddr == LSP_ADDR_PA_DIR);
        sel_lcd     = (paddr == LSP_ADDR_LCD_CTRL);
        sel_mode    = (paddr == LSP_ADDR_PWR_MODE);
        addr_hit    = sel_p8_data | sel_p8_dir | sel_pa_data
                    | sel_pa_dir | sel_lcd | sel_mode;
        // Only the low byte lane carries register bits
        wr_en       = access_ph & pwrite & pstrb[0];
    end

    // ==========================================================
    // Software registers
    // ==========================================================
    logic [7:0] p8_data_q, p8_data_d;       // Port 8 output data
    logic [7:0] p8_dir_q,  p8_dir_d;        // Port 8 direction, 1 = output
    logic [7:0] pa_data_q, pa_data_d;       // Port A output data
    logic [7:0] pa_dir_q,  pa_dir_d;        // Port A direction, 1 = output
    logic [7:0] lcd_ctrl_q, lcd_ctrl_d;     // Segment select and interface select
    lsp_mode_t  mode_q, mode_d;             // Operating mode

    // Next values: a write lands only on a hit in the access phase
    always_comb begin
        p8_data_d  = p8_data_q;
        p8_dir_d   = p8_dir_q;
        pa_data_d  = pa_data_q;
        pa_dir_d   = pa_dir_q;
        lcd_ctrl_d = lcd_ctrl_q;
        mode_d     = mode_q;
        if (wr_en) begin
            if (sel_p8_data) begin
                p8_data_d = pwdata[7:0];
            end
            if (sel_p8_dir) begin
                p8_dir_d = pwdata[7:0];
            end
            if (sel_pa_data) begin
                // Upper nibble stays at ones whatever is written
                pa_data_d = LSP_PA_FIXED | (pwdata[7:0] & LSP_PA_MASK);
            end
            if (sel_pa_dir) begin
                pa_dir_d = LSP_PA_FIXED | (pwdata[7:0] & LSP_PA_MASK);
            end
            if (sel_lcd) begin
                lcd_ctrl_d = pwdata[7:0] & LSP_LCD_MASK;
            end
            if (sel_mode) begin
                mode_d = lsp_mode_t'(pwdata[2:0]);
            end
        end
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p8_data_q  <= LSP_P8_RESET;
            p8_dir_q   <= LSP_P8_RESET;
            pa_data_q  <= LSP_PA_RESET;
            pa_dir_q   <= LSP_PA_RESET;
            lcd_ctrl_q <= LSP_LCD_RESET;
            mode_q     <= LSP_MODE_ACTIVE;
        end else begin
            p8_data_q  <= p8_data_d;
            p8_dir_q   <= p8_dir_d;
            pa_data_q  <= pa_data_d;
            pa_dir_q   <= pa_dir_d;
            lcd_ctrl_q <= lcd_ctrl_d;
            mode_q     <= mode_d;
        end
    end

    // ==========================================================
    // Mode decode from the LCD port control
    // ==========================================================
    logic [3:0] seg_sel;                    // Segment select field
    logic       if_sel;                     // Interface select
    logic       p8_gp;                      // Port 8 in general-purpose use
    logic       pa_gp;                      // Port A in general-purpose use

    always_comb begin
        seg_sel = lcd_ctrl_q[LSP_SGS_LSB +: LSP_SGS_W];
        if_sel  = lcd_ctrl_q[LSP_SGX_BIT];
        // Code 000x: lowest bit is a don't-care
        p8_gp   = (seg_sel[3:1] == 3'b000);
        pa_gp   = (seg_sel == 4'b0000);
    end

    // ==========================================================
    // Per-pin function select, port 8
    // ==========================================================
    logic [6:0] p8_func_out;                // Pad value if functional
    logic [6:0] p8_func_oe;                 // Pad enable if functional
    logic [6:0] p8_rd;                      // Read-back value per pin
    logic [2:0] lcd_if_sig;                 // Interface signals for pins 6..4

    // Pin 4 polarity, pin 5 serial data, pin 6 shift pulse
    assign lcd_if_sig = {lcd_shift_pulse, lcd_serial_data, lcd_polarity};

    for (genvar i = 0; i < LSP_P8_PINS; i++) begin : g_p8
        if (i >= LSP_P8_IF_LSB) begin : g_if
            // Interface select overrides all segment codes
            always_comb begin
                if (if_sel) begin
                    p8_func_out[i] = lcd_if_sig[i-LSP_P8_IF_LSB];
                    p8_func_oe[i]  = 1'b1;
                end else if (p8_gp) begin
                    p8_func_out[i] = p8_data_q[i];
                    p8_func_oe[i]  = p8_dir_q[i];
                end else begin
                    p8_func_out[i] = lcd_column_drive[i];
                    p8_func_oe[i]  = 1'b1;
                end
            end
        end else begin : g_seg
            // These pins ignore the interface select
            always_comb begin
                if (p8_gp) begin
                    p8_func_out[i] = p8_data_q[i];
                    p8_func_oe[i]  = p8_dir_q[i];
                end else begin
                    p8_func_out[i] = lcd_column_drive[i];
                    p8_func_oe[i]  = 1'b1;
                end
            end
        end
        // Output pins read back the latch, input pins the pad
        assign p8_rd[i] = p8_dir_q[i] ? p8_data_q[i] : p8_pin_s[i];
    end

    // ==========================================================
    // Per-pin function select, port A
    // ==========================================================
    logic [3:0] pa_func_out;                // Pad value if functional
    logic [3:0] pa_func_oe;                 // Pad enable if functional
    logic [3:0] pa_rd;                      // Read-back value per pin

    for (genvar j = 0; j < LSP_PA_PINS; j++) begin : g_pa
        // Pad drive honours data and direction only in gpio use; read-back always does
        assign pa_func_out[j] = pa_gp ? pa_data_q[j] : lcd_backplane[j];
        assign pa_func_oe[j]  = pa_gp ? pa_dir_q[j] : 1'b1;
        assign pa_rd[j]       = pa_dir_q[j] ? pa_data_q[j] : pa_pin_s[j];
    end

    // ==========================================================
    // Pad output stage with operating-mode gating
    // ==========================================================
    logic [6:0] p8_out_q, p8_out_d;         // Registered pad drive
    logic [6:0] p8_oe_q,  p8_oe_d;
    logic [3:0] pa_out_q, pa_out_d;
    logic [3:0] pa_oe_q,  pa_oe_d;

    // Next values: sleep states freeze the pads as they were
    always_comb begin
        p8_out_d = p8_func_out;
        p8_oe_d  = p8_func_oe;
        pa_out_d = pa_func_out;
        pa_oe_d  = pa_func_oe;
        case (mode_q)
            LSP_MODE_SLEEP, LSP_MODE_SUBSLEEP, LSP_MODE_WATCH: begin
                p8_out_d = p8_out_q;
                p8_oe_d  = p8_oe_q;
                pa_out_d = pa_out_q;
                pa_oe_d  = pa_oe_q;
            end
            LSP_MODE_STANDBY: begin
                // Float the pads; value kept for a tidy wake-up
                p8_out_d = p8_out_q;
                p8_oe_d  = '0;
                pa_out_d = pa_out_q;
                pa_oe_d  = '0;
            end
            default: begin
                // Active, subactive, and unused codes run normally
                p8_out_d = p8_func_out;
                p8_oe_d  = p8_func_oe;
                pa_out_d = pa_func_out;
                pa_oe_d  = pa_func_oe;
            end
        endcase
    end

    // Registers: reset releases every pad
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p8_out_q <= '0;
            p8_oe_q  <= '0;
            pa_out_q <= '0;
            pa_oe_q  <= '0;
        end else begin
            p8_out_q <= p8_out_d;
            p8_oe_q  <= p8_oe_d;
            pa_out_q <= pa_out_d;
            pa_oe_q  <= pa_oe_d;
        end
    end

    assign port8_pin_out  = p8_out_q;
    assign port8_pin_oe   = p8_oe_q;
    assign port_a_pin_out = pa_out_q;
    assign port_a_pin_oe  = pa_oe_q;

    // ==========================================================
    // Read data and response
    // ==========================================================
    logic [7:0]  rd_byte;                   // Selected register view
    logic [31:0] prdata_q, prdata_d;
    logic        slverr_q, slverr_d;

    // Read view of the addressed register
    always_comb begin
        rd_byte = 8'h00;
        if (sel_p8_data) begin
            // Pin 7 lies outside this block; its latch reads back
            rd_byte = {p8_data_q[7], p8_rd};
        end else if (sel_p8_dir) begin
            rd_byte = LSP_DIR_READ;
        end else if (sel_pa_data) begin
            rd_byte = LSP_PA_FIXED | {4'h0, pa_rd};
        end else if (sel_pa_dir) begin
            rd_byte = LSP_DIR_READ;
        end else if (sel_lcd) begin
            rd_byte = lcd_ctrl_q;
        end else if (sel_mode) begin
            rd_byte = {5'h00, mode_q};
        end
    end

    // Capture in the setup cycle so data stands through the access phase
    always_comb begin
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        if (setup_ph) begin
            prdata_d = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            slverr_d = ~addr_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    // Zero wait states: every access phase completes at once
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = slverr_q & access_ph;

endmodule : lsp_port_mux

`default_nettype wire

// ---- sim/lsp_port_mux_sva.sv ----
// Checker: pad and read-back assertions for the port multiplexer
`default_nettype none
module lsp_port_mux_chk
    import lsp_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic [6:0]  lcd_column_drive,
    input wire logic        lcd_shift_pulse,
    input wire logic        lcd_serial_data,
    input wire logic        lcd_polarity,
    input wire logic [3:0]  lcd_backplane,
    input wire logic [6:0]  port8_pin_out,
    input wire logic [6:0]  port8_pin_oe,
    input wire logic [3:0]  port_a_pin_out,
    input wire logic [3:0]  port_a_pin_oe
);
    // ==========
    // Shadow of committed control writes
    logic [4:0] ctl_q, ctl_d;     // Segment and interface select
    logic [2:0] md_q, md_d;       // Operating mode
    logic [6:0] d8_q, d8_d;       // Port 8 direction
    logic [3:0] da_q, da_d;       // Port A direction
    logic [1:0] qt_q, qt_d;       // Edges since any write, saturating
    logic       wr, run, frz, ok, g8;
    wire  [6:0] o8 = port8_pin_out;
    wire  [6:0] e8 = port8_pin_oe;
    wire  [3:0] oa = port_a_pin_out;
    wire  [3:0] ea = port_a_pin_oe;
    // Next shadow values
    always_comb begin
        wr    = psel && penable && pwrite && pstrb[0];
        ctl_d = (wr && paddr == LSP_ADDR_LCD_CTRL) ? pwdata[4:0] : ctl_q;
        md_d  = (wr && paddr == LSP_ADDR_PWR_MODE) ? pwdata[2:0] : md_q;
        d8_d  = (wr && paddr == LSP_ADDR_P8_DIR) ? pwdata[6:0] : d8_q;
        da_d  = (wr && paddr == LSP_ADDR_PA_DIR) ? pwdata[3:0] : da_q;
        qt_d  = wr ? 2'd0 : ((qt_q == 2'd3) ? qt_q : qt_q + 2'd1);
    end
    // Shadow registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 5'h00;
            md_q  <= 3'h0;
            d8_q  <= 7'h00;
            da_q  <= 4'h0;
            qt_q  <= 2'd0;
        end else begin
            ctl_q <= ctl_d;
            md_q  <= md_d;
            d8_q  <= d8_d;
            da_q  <= da_d;
            qt_q  <= qt_d;
        end
    end
    // Two edges of margin hide the pad register
    assign run = md_q < 3'd2 || md_q > 3'd5;
    assign frz = md_q >= 3'd2 && md_q <= 3'd4;
    assign ok  = run && qt_q >= 2'd2;
    assign g8  = ctl_q[3:1] == 3'd0;
    // ==========
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_lo; ok && !g8 |-> e8[3:0] == 4'hf && o8[3:0] == $past(lcd_column_drive[3:0]);
    endproperty
    a_lo: assert property (p_lo) else $error("pins 3..0 miss column drive");
    property p_if; ok && ctl_q[4] |-> e8[6:4] == 3'h7
        && o8[6:4] == $past({lcd_shift_pulse, lcd_serial_data, lcd_polarity}); endproperty
    a_if: assert property (p_if) else $error("pins 6..4 miss interface");
    property p_hi; ok && !ctl_q[4] && !g8 |-> o8[6:4] == $past(lcd_column_drive[6:4]);
    endproperty
    a_hi: assert property (p_hi) else $error("pins 6..4 miss column");
    property p_gp; ok && g8 && !ctl_q[4] |-> e8 == d8_q; endproperty
    a_gp: assert property (p_gp) else $error("port 8 enable not direction");
    property p_ag; ok && ctl_q[3:0] == 4'h0 |-> ea == da_q; endproperty
    a_ag: assert property (p_ag) else $error("port A enable not direction");
    property p_al; ok && ctl_q[3:0] != 4'h0 |-> ea == 4'hf && oa == $past(lcd_backplane);
    endproperty
    a_al: assert property (p_al) else $error("port A misses backplane");
    property p_sb; qt_q >= 2'd2 && md_q == 3'd5 |-> e8 == 7'h00 && ea == 4'h0; endproperty
    a_sb: assert property (p_sb) else $error("pads driven in standby");
    property p_fz; frz && $past(frz) |-> $stable({o8, e8, oa, ea}); endproperty
    a_fz: assert property (p_fz) else $error("pads moved while frozen");
    property p_dr; psel && penable && !pwrite
        && (paddr == LSP_ADDR_PA_DIR || paddr == LSP_ADDR_P8_DIR) |-> prdata == 32'h0000_00ff;
    endproperty
    a_dr: assert property (p_dr) else $error("direction read not all ones");
    property p_ar; psel && penable && !pwrite && paddr == LSP_ADDR_PA_DATA
        |-> prdata[31:4] == 28'h000_000f; endproperty
    a_ar: assert property (p_ar) else $error("port A upper bits not ones");
    c_if: cover property (ok && ctl_q[4]);
    c_fz: cover property (frz && $past(frz));
    c_sb: cover property (md_q == 3'd5 && qt_q == 2'd3);
endmodule // lsp_port_mux_chk

bind lsp_port_mux lsp_port_mux_chk u_chk (.*);
`default_nettype wire

// ---- sim/lsp_far_model.sv ----
// Far side: LCD controller pattern source and pad wiring
`default_nettype none
module lsp_far_model (
    input  wire logic       pclk,
    input  wire logic       run,
    input  wire logic [6:0] ext8,
    input  wire logic [3:0] exta,
    input  wire logic [6:0] p8o,
    input  wire logic [6:0] p8e,
    input  wire logic [3:0] pao,
    input  wire logic [3:0] pae,
    output logic      [6:0] p8i,
    output logic      [3:0] pai,
    output logic      [6:0] col,
    output logic            sh,
    output logic            sd,
    output logic            pol,
    output logic      [3:0] bp
);
    // ==========
    // Pattern moves while run is high, so stale drive shows
    logic [10:0] cnt_q = 11'h4d5;   // Start value, arbitrary
    always @(posedge pclk) begin
        if (run) begin
            cnt_q <= cnt_q + 11'd1;
        end
    end
    assign col           = cnt_q[6:0];
    assign {sh, sd, pol} = cnt_q[9:7];
    assign bp            = cnt_q[10:7];
    // ==========
    // Pads: the driving side wins, else the outside level
    assign p8i = (p8e & p8o) | (~p8e & ext8);
    assign pai = (pae & pao) | (~pae & exta);
endmodule // lsp_far_model
`default_nettype wire

// ---- sim/lsp_port_mux_bench.sv ----
// Testbench: self-checking run of the LCD-shared port multiplexer
`default_nettype none
module lsp_port_mux_bench
    import lsp_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, run, sh, sd, pol, rerr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb, exta, pai, pao, pae, bp;
    logic [6:0]  ext8, p8i, p8o, p8e, col;
    int          bad_count, compares, cyc;
    lsp_port_mux u_dut (
        .*, .lcd_column_drive(col), .lcd_shift_pulse(sh),
        .lcd_serial_data(sd), .lcd_polarity(pol), .lcd_backplane(bp),
        .port8_pin_in(p8i), .port8_pin_out(p8o), .port8_pin_oe(p8e),
        .port_a_pin_in(pai), .port_a_pin_out(pao), .port_a_pin_oe(pae)
    );
    lsp_far_model u_far (.*);
    // ==========
    // Clock and hang guard; the run needs under a thousand cycles
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            conclude();
        end
    end
    // ==========
    // Shared tasks
    task automatic conclude();
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, 24'h00_0000, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
        apb(1'b1, a, d, s, rdat, rerr);
    endtask
    task automatic rdc(input logic [17:0] a, input logic [31:0] x);
        apb(1'b0, a, 8'h00, 4'hf, rdat, rerr);
        chk(rdat, x);
    endtask
    // Past the edge's pad updates
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // ==========
    // Scenarios
    task automatic t_regs();
        chk(32'({p8e, pae}), 32'h0000_0000);
        rdc(LSP_ADDR_PA_DIR, 32'h0000_00ff);
        rdc(LSP_ADDR_P8_DIR, 32'h0000_00ff);
        rdc(LSP_ADDR_PA_DATA, 32'h0000_00f5);
        wr(LSP_ADDR_PA_DIR, 8'h0f, 4'h0);
        rdc(LSP_ADDR_PA_DATA, 32'h0000_00f5);
        apb(1'b0, 18'h0_0010, 8'h00, 4'hf, rdat, rerr);
        chk(32'(rerr), 32'h0000_0001);
        chk(rdat, 32'h0000_0000);
    endtask
    task automatic t_gpio();
        wr(LSP_ADDR_P8_DIR, 8'h5f);
        wr(LSP_ADDR_P8_DATA, 8'h2a);
        wr(LSP_ADDR_PA_DIR, 8'h0a);
        wr(LSP_ADDR_PA_DATA, 8'h03);
        settle(3);
        chk(32'(p8e), 32'h0000_005f);
        chk(32'(p8o & p8e), 32'h0000_000a);
        chk(32'(pae), 32'h0000_000a);
        chk(32'(pao & pae), 32'h0000_0002);
        rdc(LSP_ADDR_PA_DATA, 32'h0000_00f7);
        rdc(LSP_ADDR_P8_DATA, 32'h0000_000a);
    endtask
    // All select codes, both interface settings, still pattern
    task automatic t_lcd();
        logic [6:0] x8, m8;
        logic       g;
        for (int x = 0; x < 32; x++) begin
            wr(LSP_ADDR_LCD_CTRL, 8'(x));
            settle(3);
            g       = (x[3:1] == 3'd0);
            m8      = {1'b1, x[4] || !g, 5'h1f};
            x8[3:0] = g ? 4'ha : col[3:0];
            x8[6:4] = x[4] ? {sh, sd, pol} : (g ? 3'b010 : col[6:4]);
            chk(32'(p8e), 32'(m8));
            chk(32'(p8o & m8), 32'(x8 & m8));
            chk(32'(pae), (x[3:0] == 4'h0) ? 32'h0000_000a : 32'h0000_000f);
            chk(32'(pao & pae), (x[3:0] == 4'h0) ? 32'h0000_0002 : 32'(bp));
        end
        // Moving pattern, judged by the checker
        @(posedge pclk);
        run <= 1'b1;
        wr(LSP_ADDR_LCD_CTRL, 8'h12);
        settle(20);
        wr(LSP_ADDR_LCD_CTRL, 8'h04);
        settle(20);
        wr(LSP_ADDR_LCD_CTRL, 8'h00);
        @(posedge pclk);
        run <= 1'b0;
    endtask
    task automatic t_modes();
        for (int m = 2; m <= 4; m++) begin
            wr(LSP_ADDR_PWR_MODE, 8'(m));
            wr(LSP_ADDR_P8_DATA, 8'h55);
            settle(3);
            chk(32'(p8o & p8e), 32'h0000_000a);
            wr(LSP_ADDR_PWR_MODE, 8'h00);
            wr(LSP_ADDR_P8_DATA, 8'h2a);
        end
        wr(LSP_ADDR_PWR_MODE, 8'h05);
        settle(3);
        chk(32'({p8e, pae}), 32'h0000_0000);
        wr(LSP_ADDR_PWR_MODE, 8'h01);
        wr(LSP_ADDR_P8_DATA, 8'h55);
        settle(3);
        chk(32'(p8o & p8e), 32'h0000_0055);
        @(posedge pclk);
        presetn <= 1'b0;
        settle(2);
        chk(32'({p8e, pae}), 32'h0000_0000);
        @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
    endtask
    // ==========
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, run, presetn} = '0;
        ext8    = 7'h13;
        exta    = 4'h5;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        t_regs();
        t_gpio();
        t_lcd();
        t_modes();
        conclude();
    end
endmodule // lsp_port_mux_bench
`default_nettype wire
